// [verilog/pia_ctrl.sv]
/*
 * Interrupt acceptance and prioritisation with exception start-up:
 * stack save, mask update, vector fetch and jump toward the core.
 * Assumes single-cycle memory (read data one cycle after the read
 * strobe) and a core on clk_sys that pulses excAck at an instruction
 * boundary.
 */
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module pia_ctrl (
	input wire logic clk_sys,
	input wire logic rst,
	input wire pia_pkg::pia_bus_s busReq,
	output logic [pia_pkg::DATA_W-1:0] busRdata,
	input wire logic [pia_pkg::NUM_IRQ-1:0] irqPinN,
	input wire logic nmiPinN,
	input wire logic standbyPin,
	input wire logic [pia_pkg::NUM_VEC-1:0] modCond,
	input wire logic excAck,
	input wire logic [pia_pkg::PC_W-1:0] nextPc,
	input wire logic [7:0] condIn,
	input wire logic [pia_pkg::PC_W-1:0] spIn,
	input wire logic [pia_pkg::DATA_W-1:0] memRdata,
	output logic irqReq,
	output logic [pia_pkg::VEC_W-1:0] vecNum,
	output pia_pkg::pia_mem_s memOut,
	output logic jump,
	output logic [pia_pkg::PC_W-1:0] jumpPc,
	output logic maskI,
	output logic maskSec
);
	import pia_pkg::*;

	pia_state_s s_q;
	pia_state_s s_d;

	logic [NUM_VEC-1:0] reqVec;
	logic [NUM_VEC-1:0] cand;
	logic [NUM_VEC-1:0] lvlVec;
	logic [NUM_VEC-1:0] allow;
	logic [NUM_VEC-1:0] elig;
	logic [NUM_VEC-1:0] pool;
	logic [VEC_W-1:0] win;
	logic found;
	logic nmiEdge;
	logic nmiOk;
	logic [7:0] condPush;

	// ****************************************
	// request gathering and selection
	// ****************************************
	always_comb begin
		nmiEdge = s_q.nmiOld & ~s_q.nmiS2;
		nmiOk = s_q.nmiPend & ~s_q.stbyS2;
		reqVec = modCond & VALID_VECS;
		reqVec[VEC_IRQ0 +: NUM_IRQ] = ~s_q.irqS2;
		cand = reqVec & s_q.ena;
		for (int i = 0; i < NUM_VEC; i++) begin
			lvlVec[i] = prioLvl(VEC_W'(i), s_q.prioA, s_q.prioB);
			if (s_q.modeSel) begin
				allow[i] = ~s_q.maskI;
			end else begin
				allow[i] = ~s_q.maskI | (~s_q.maskSec & lvlVec[i]);
			end
		end
		elig = cand & allow;
		pool = (|(elig & lvlVec)) ? (elig & lvlVec) : elig;
		win = '0;
		found = 1'h0;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (pool[i]) begin
				win = VEC_W'(i);
				found = 1'h1;
			end
		end
		condPush = condIn;
		condPush[PUSH_I_BIT] = s_q.maskI;
		condPush[PUSH_SEC_BIT] = s_q.maskSec;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		s_d.jump = 1'h0;
		s_d.irqS1 = irqPinN;
		s_d.irqS2 = s_q.irqS1;
		s_d.nmiS1 = nmiPinN;
		s_d.nmiS2 = s_q.nmiS1;
		s_d.nmiOld = s_q.nmiS2;
		s_d.stbyS1 = standbyPin;
		s_d.stbyS2 = s_q.stbyS1;
		if (s_q.stbyS2) begin
			s_d.nmiPend = 1'h0;
		end

		if (busReq.wr) begin
			unique case (busReq.addr)
				OFF_PRIO_A: s_d.prioA = busReq.wdata[7:0];
				OFF_PRIO_B: s_d.prioB = busReq.wdata[7:0];
				OFF_SYSCTL: begin
					s_d.modeSel = busReq.wdata[SYS_MODE_BIT];
					s_d.advMode = busReq.wdata[SYS_ADV_BIT];
				end
				OFF_MASK: begin
					s_d.maskI = busReq.wdata[MASK_I_BIT];
					s_d.maskSec = busReq.wdata[MASK_SEC_BIT];
				end
				OFF_ENA_LO: s_d.ena[31:0] = busReq.wdata;
				OFF_ENA_HI: s_d.ena[63:32] = busReq.wdata;
				default: ;
			endcase
		end
		if (busReq.rd) begin
			unique case (busReq.addr)
				OFF_PRIO_A: s_d.rdata = {24'h000000, s_q.prioA};
				OFF_PRIO_B: s_d.rdata = {24'h000000, s_q.prioB};
				OFF_SYSCTL: s_d.rdata = {30'h00000000, s_q.advMode, s_q.modeSel};
				OFF_MASK: s_d.rdata = {30'h00000000, s_q.maskSec, s_q.maskI};
				OFF_ENA_LO: s_d.rdata = s_q.ena[31:0];
				OFF_ENA_HI: s_d.rdata = s_q.ena[63:32];
				OFF_STATUS: s_d.rdata = {11'h000, s_q.fsm, 6'h00, s_q.nmiPend,
					s_q.irqReq, 2'h0, s_q.vec};
				OFF_PEND_LO: s_d.rdata = cand[31:0];
				OFF_PEND_HI: s_d.rdata = cand[63:32];
				default: s_d.rdata = '0;
			endcase
		end

		unique case (s_q.fsm)
			ST_IDLE: begin
				if (nmiOk) begin
					s_d.nmiPend = 1'h0;
					s_d.vec = VEC_NMI;
					s_d.irqReq = 1'h1;
					s_d.fsm = ST_HOLD;
				end else if (found) begin
					s_d.vec = win;
					s_d.irqReq = 1'h1;
					s_d.fsm = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (excAck) begin
					s_d.irqReq = 1'h0;
					s_d.mem.wr = 1'h1;
					s_d.mem.addr = spIn - STACK_STEP;
					s_d.mem.wdata = {condPush, nextPc};
					s_d.fsm = ST_SAVE;
				end
			end
			ST_SAVE: begin
				s_d.mem.wr = 1'h0;
				s_d.maskI = 1'h1;
				if (!s_q.modeSel) begin
					s_d.maskSec = 1'h1;
				end
				s_d.mem.rd = 1'h1;
				s_d.mem.addr = {8'h00, vecAddr(s_q.vec, s_q.advMode)};
				s_d.mem.wdata = '0;
				s_d.fsm = ST_FETCH;
			end
			ST_FETCH: begin
				s_d.mem.rd = 1'h0;
				s_d.fsm = ST_LOAD;
			end
			ST_LOAD: begin
				s_d.jump = 1'h1;
				s_d.jumpPc = memRdata[PC_W-1:0];
				s_d.fsm = ST_IDLE;
			end
		endcase
		// a new edge wins over the acceptance clear
		if (nmiEdge && !s_q.stbyS2) begin
			s_d.nmiPend = 1'h1;
		end

		if (rst) begin
			s_d = '0;
			s_d.fsm = ST_IDLE;
			s_d.irqS1 = '1;
			s_d.irqS2 = '1;
			s_d.nmiS1 = 1'h1;
			s_d.nmiS2 = 1'h1;
			s_d.nmiOld = 1'h1;
			s_d.prioA = PRIO_RST;
			s_d.prioB = PRIO_RST;
			s_d.modeSel = MODE_RST;
			s_d.advMode = ADV_RST;
			s_d.maskI = MASK_I_RST;
			s_d.maskSec = MASK_SEC_RST;
			s_d.ena = {ENA_RST, ENA_RST};
		end
	end

	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign busRdata = s_q.rdata;
	assign irqReq = s_q.irqReq;
	assign vecNum = s_q.vec;
	assign memOut = s_q.mem;
	assign jump = s_q.jump;
	assign jumpPc = s_q.jumpPc;
	assign maskI = s_q.maskI;
	assign maskSec = s_q.maskSec;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	hold_stable_a: assert property (
		s_q.fsm == ST_HOLD && !excAck |=> s_q.irqReq && $stable(s_q.vec))
		else $error("vector changed before acknowledge");

	defer_start_a: assert property (
		s_q.irqReq && !excAck |=> !s_q.mem.wr && s_q.fsm == ST_HOLD)
		else $error("handling started before instruction end");

	save_push_a: assert property (
		s_q.fsm == ST_HOLD && excAck |=> s_q.mem.wr
		&& s_q.mem.wdata[PC_W-1:0] == $past(nextPc)
		&& s_q.mem.addr == $past(spIn) - STACK_STEP)
		else $error("stack push wrong");

	mask_one_a: assert property (
		s_q.fsm == ST_SAVE && s_q.modeSel |=> s_q.maskI && $stable(s_q.maskSec))
		else $error("global mask not set after save");

	mask_both_a: assert property (
		s_q.fsm == ST_SAVE && !s_q.modeSel |=> s_q.maskI && s_q.maskSec)
		else $error("mask flags not set after save");

	vec_fetch_a: assert property (
		s_q.fsm == ST_SAVE |=> s_q.mem.rd
		&& s_q.mem.addr[15:0] == vecAddr(s_q.vec, s_q.advMode)
		##2 s_q.jump && s_q.jumpPc == $past(memRdata[PC_W-1:0]))
		else $error("vector fetch or jump wrong");

	nmi_take_a: assert property (
		s_q.fsm == ST_IDLE && s_q.nmiPend && !s_q.stbyS2
		|=> s_q.irqReq && s_q.vec == VEC_NMI)
		else $error("non-maskable request not taken");

	mask_block_a: assert property (
		s_q.fsm == ST_IDLE && s_q.maskI && (s_q.modeSel || s_q.maskSec)
		&& !s_q.nmiPend |=> !s_q.irqReq)
		else $error("masked request accepted");

	lvl_pass_a: assert property (
		s_q.fsm == ST_IDLE && !s_q.nmiPend && s_q.maskI && !s_q.modeSel
		&& !s_q.maskSec && |(cand & lvlVec)
		|=> s_q.irqReq && lvlVec[s_q.vec])
		else $error("level 1 request not accepted");

	tie_order_a: assert property (
		s_q.fsm == ST_IDLE && !nmiOk && found
		|=> s_q.vec == $past(win)
		&& ($past(pool) & ((64'h1 << s_q.vec) - 64'h1)) == 64'h0)
		else $error("tie not broken by vector order");

	enable_gate_a: assert property (
		s_q.fsm == ST_IDLE && !nmiOk && found |-> s_q.ena[win])
		else $error("disabled request selected");

	// ****************************************
	// reset, selection and sequence checks
	// ****************************************
	reset_out_a: assert property (
		disable iff (1'h0) rst |=> !s_q.irqReq && !s_q.jump && s_q.fsm == ST_IDLE
		&& s_q.maskI == MASK_I_RST && s_q.prioA == PRIO_RST && s_q.prioB == PRIO_RST)
		else $error("state not cleared by reset");

	stby_block_a: assert property (
		s_q.stbyS2 |=> !s_q.nmiPend)
		else $error("non-maskable request pending in standby");

	nmi_latch_a: assert property (
		nmiEdge && !s_q.stbyS2 |=> s_q.nmiPend)
		else $error("non-maskable edge lost");

	disabled_idle_a: assert property (
		s_q.fsm == ST_IDLE && !nmiOk && cand == '0
		|=> !s_q.irqReq)
		else $error("request taken without enable");

	mode_one_open_a: assert property (
		s_q.fsm == ST_IDLE && s_q.modeSel && !s_q.maskI && |cand
		|=> s_q.irqReq)
		else $error("unmasked request refused in mode 1");

	mode_zero_open_a: assert property (
		s_q.fsm == ST_IDLE && !s_q.modeSel && !s_q.maskI && |cand
		|=> s_q.irqReq)
		else $error("unmasked request refused in mode 0");

	level_zero_hold_a: assert property (
		s_q.fsm == ST_IDLE && !nmiOk && !s_q.modeSel && s_q.maskI && !s_q.maskSec
		&& !(|(cand & lvlVec)) |=> !s_q.irqReq)
		else $error("level 0 request accepted under global mask");

	level_rank_a: assert property (
		s_q.fsm == ST_IDLE && !nmiOk && |(elig & lvlVec)
		|=> lvlVec[s_q.vec])
		else $error("level 0 request outranked level 1");

	ack_release_a: assert property (
		s_q.fsm == ST_HOLD && excAck |=> !s_q.irqReq && s_q.fsm == ST_SAVE)
		else $error("request not released after acknowledge");

	req_in_hold_a: assert property (
		s_q.irqReq |-> s_q.fsm == ST_HOLD)
		else $error("request shown outside hold");

	save_flags_a: assert property (
		s_q.fsm == ST_HOLD && excAck
		|=> s_q.mem.wdata[PC_W + PUSH_I_BIT] == $past(s_q.maskI)
		&& s_q.mem.wdata[PC_W + PUSH_SEC_BIT] == $past(s_q.maskSec))
		else $error("pushed mask flags wrong");

	wr_pulse_a: assert property (
		s_q.mem.wr |=> !s_q.mem.wr && s_q.mem.rd)
		else $error("stack write not followed by vector read");

	fetch_order_a: assert property (
		s_q.fsm == ST_FETCH |=> s_q.fsm == ST_LOAD && !s_q.mem.rd)
		else $error("fetch stage out of order");

	load_stage_a: assert property (
		s_q.fsm == ST_LOAD
		|=> s_q.jump && s_q.jumpPc == $past(memRdata[PC_W-1:0]))
		else $error("handler address not loaded");

	jump_pulse_a: assert property (
		s_q.jump |-> s_q.fsm == ST_IDLE && !s_q.irqReq ##1 !s_q.jump)
		else $error("jump not a single pulse");

	idle_quiet_a: assert property (
		s_q.fsm == ST_IDLE |-> !s_q.mem.wr && !s_q.mem.rd)
		else $error("memory access while idle");

	vec_valid_a: assert property (
		s_q.irqReq |-> VALID_VECS[s_q.vec] || s_q.vec == VEC_NMI)
		else $error("accepted vector has no source");

	vec_space_a: assert property (
		s_q.mem.rd |-> s_q.mem.addr[23:16] == 8'h00 && s_q.mem.addr[0] == 1'h0)
		else $error("vector address outside table");

	sec_ignored_a: assert property (
		s_q.fsm == ST_IDLE && s_q.modeSel && !s_q.maskI && s_q.maskSec && |cand
		|=> s_q.irqReq)
		else $error("secondary flag masked in mode 1");

endmodule

// [verilog/pia_pkg.sv]
/*
 * Shared definitions for the prioritised interrupt acceptance block:
 * register offsets, field positions, reset values, vector constants,
 * carrier structs, the state type and the priority/vector functions.
 * Assumes a 32-bit register port with byte offsets on 8 address bits.
 */
package pia_pkg;

	// ****************************************
	// widths and offsets
	// ****************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int VEC_W = 6;
	localparam int NUM_VEC = 64;
	localparam int PC_W = 24;
	localparam int NUM_IRQ = 6;

	localparam logic [ADDR_W-1:0] OFF_PRIO_A = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PRIO_B = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SYSCTL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_ENA_LO = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ENA_HI = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_PEND_LO = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_PEND_HI = 8'h20;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int SYS_MODE_BIT = 0;
	localparam int SYS_ADV_BIT = 1;
	localparam int MASK_I_BIT = 0;
	localparam int MASK_SEC_BIT = 1;
	localparam int PUSH_I_BIT = 7;
	localparam int PUSH_SEC_BIT = 6;
	localparam logic [7:0] PRIO_RST = 8'h00;
	localparam logic MODE_RST = 1'h1;
	localparam logic ADV_RST = 1'h1;
	localparam logic MASK_I_RST = 1'h1;
	localparam logic MASK_SEC_RST = 1'h0;
	localparam logic [31:0] ENA_RST = 32'h0000_0000;

	localparam logic [VEC_W-1:0] VEC_NMI = 6'h07;
	localparam int VEC_IRQ0 = 12;
	localparam logic [NUM_VEC-1:0] VALID_VECS = 64'hFFF0_FFF7_77B3_F000;
	localparam logic [PC_W-1:0] STACK_STEP = 24'h000004;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HOLD = 5'h02,
		ST_SAVE = 5'h04,
		ST_FETCH = 5'h08,
		ST_LOAD = 5'h10
	} pia_fsm_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pia_bus_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [PC_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pia_mem_s;

	typedef struct packed {
		pia_fsm_e fsm;
		logic [NUM_IRQ-1:0] irqS1;
		logic [NUM_IRQ-1:0] irqS2;
		logic nmiS1;
		logic nmiS2;
		logic nmiOld;
		logic stbyS1;
		logic stbyS2;
		logic nmiPend;
		logic [7:0] prioA;
		logic [7:0] prioB;
		logic modeSel;
		logic advMode;
		logic maskI;
		logic maskSec;
		logic [NUM_VEC-1:0] ena;
		logic irqReq;
		logic [VEC_W-1:0] vec;
		pia_mem_s mem;
		logic jump;
		logic [PC_W-1:0] jumpPc;
		logic [DATA_W-1:0] rdata;
	} pia_state_s;

	// ****************************************
	// functions
	// ****************************************
	// priority level bit of a vector, zero where no bit is assigned
	function automatic logic prioLvl(input logic [VEC_W-1:0] v, input logic [7:0] pa,
		input logic [7:0] pb);
		logic r;
		r = 1'h0;
		case (v) inside
			6'h0C: r = pa[7];
			6'h0D: r = pa[6];
			[6'h0E:6'h0F]: r = pa[5];
			[6'h10:6'h11]: r = pa[4];
			[6'h14:6'h17]: r = pa[3];
			[6'h18:6'h1B]: r = pa[2];
			[6'h1C:6'h1F]: r = pa[1];
			[6'h20:6'h23]: r = pa[0];
			[6'h24:6'h27]: r = pb[7];
			[6'h28:6'h2B]: r = pb[6];
			[6'h2C:6'h2F]: r = pb[5];
			[6'h34:6'h37]: r = pb[3];
			[6'h38:6'h3B]: r = pb[2];
			[6'h3C:6'h3F]: r = pb[1];
			default: r = 1'h0;
		endcase
		return r;
	endfunction

	// lower 16 bits of the vector table entry address
	function automatic logic [15:0] vecAddr(input logic [VEC_W-1:0] v, input logic adv);
		return adv ? {8'h00, v, 2'h0} : {9'h000, v, 1'h0};
	endfunction

endpackage

// [tb/pia_core_model.sv]
/* Core and memory stand-in for pia_ctrl: acknowledges at an instruction
 * boundary, supplies pc, condition byte and sp, answers vector reads.
 * Assumes the clk_sys and rst of the block under test. */
`timescale 1ns/10ps
module pia_core_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic slow,
	input wire logic irqReq,
	input wire pia_pkg::pia_mem_s memOut,
	input wire logic jump,
	output logic excAck,
	output logic [pia_pkg::PC_W-1:0] nextPc,
	output logic [7:0] condIn,
	output logic [pia_pkg::PC_W-1:0] spIn,
	output logic [31:0] memRdata
);
	import pia_pkg::*;
	logic [3:0] cnt_q;
	logic acked_q;
	logic [31:0] noise_q;
	assign nextPc = 24'h012344;
	assign condIn = 8'h0A;
	assign spIn = 24'h00FF00;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			excAck <= 1'h0;
			acked_q <= 1'h0;
			cnt_q <= 4'h0;
			noise_q <= 32'h0;
			memRdata <= 32'h0;
		end else begin
			noise_q <= noise_q + 32'h9E37;
			excAck <= 1'h0;
			if (irqReq && !acked_q) begin
				if (cnt_q == (slow ? 4'h6 : 4'h0)) begin
					excAck <= 1'h1;
					acked_q <= 1'h1;
					cnt_q <= 4'h0;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
			if (jump) begin
				acked_q <= 1'h0;
			end
			// handler word encodes the vector address it was read from
			memRdata <= memOut.rd ? {16'h0010, memOut.addr[15:0]} : ~noise_q;
		end
	end
endmodule

// [tb/test_prioritised_interrupt_acceptance.sv]
/* Self-checking bench for pia_ctrl: random sources, levels, enables and
 * mask modes; expected vectors are queued and compared on each jump.
 * Assumes pia_core_model as core and memory. */
`timescale 1ns/10ps
module test_prioritised_interrupt_acceptance;
	import pia_pkg::*;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	pia_bus_s busReq = '0;
	logic [5:0] irqPinN = 6'h3F;
	logic nmiPinN = 1'h1;
	logic standbyPin = 1'h0;
	logic [63:0] modCond = 64'h0;
	logic slow = 1'h0;
	logic excAck, irqReq, jump, maskI, maskSec;
	logic [23:0] nextPc, spIn, jumpPc;
	logic [7:0] condIn;
	logic [31:0] memRdata, busRdata;
	logic [5:0] vecNum, mv;
	pia_mem_s memOut;
	logic [31:0] seed = 32'hAB03;
	logic m0 = 1'h0;
	logic adv = 1'h1;
	logic [1:0] mk = 2'h3;
	logic [5:0] expQ[$];
	int checks = 0;
	int badCount = 0;
	int cyc = 0;

	pia_ctrl i_dut (.clk_sys, .rst, .busReq, .busRdata, .irqPinN, .nmiPinN, .standbyPin,
		.modCond, .excAck, .nextPc, .condIn, .spIn, .memRdata, .irqReq, .vecNum, .memOut,
		.jump, .jumpPc, .maskI, .maskSec);
	pia_core_model i_core (.clk_sys, .rst, .slow, .irqReq, .memOut, .jump, .excAck,
		.nextPc, .condIn, .spIn, .memRdata);

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// ********
	// helpers
	// ********
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic lvl(input int v, input logic [15:0] p);
		if (v < 14) return p[27 - v];
		if (v < 20) return p[13 - (v - 14) / 2];
		return p[11 - (v - 20) / 4];
	endfunction

	function automatic int pickVec(input logic [63:0] r, input logic [15:0] p,
		input logic [1:0] msk, input logic mode0);
		int b = -1;
		for (int v = 12; v < 64; v++) begin
			if (r[v] && (!msk[0] || (mode0 && !msk[1] && lvl(v, p)))
				&& (b < 0 || (lvl(v, p) && !lvl(b, p)))) b = v;
		end
		return b;
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		busReq <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk_sys);
		busReq <= '0;
		@(posedge clk_sys);
	endtask

	task automatic regRd(input logic [7:0] a, input logic [31:0] e, input string n);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
		@(posedge clk_sys);
		busReq <= '0;
		@(negedge clk_sys);
		chk(n, e, busRdata);
		@(posedge clk_sys);
	endtask

	task automatic round(input logic mode0, input logic ad, input logic [1:0] msk,
		input logic [15:0] p);
		logic [63:0] req;
		logic [63:0] ena;
		int v;
		req = ({rnd(), rnd()} & VALID_VECS) | 64'hC000;
		ena = {rnd(), rnd()} | 64'hC000;
		m0 = mode0;
		adv = ad;
		slow <= seed[0];
		regWr(OFF_PRIO_A, {24'h0, p[15:8]});
		regWr(OFF_PRIO_B, {24'h0, p[7:0]});
		regWr(OFF_SYSCTL, {30'h0, ad, ~mode0});
		regWr(OFF_ENA_LO, ena[31:0]);
		regWr(OFF_ENA_HI, ena[63:32]);
		modCond <= req & ~64'h3F000;
		irqPinN <= ~req[17:12];
		repeat (4) @(posedge clk_sys);
		mk = msk;
		for (int k = 0; k < 40; k++) begin
			v = pickVec(req & ena, p, msk, mode0);
			regWr(OFF_MASK, {30'h0, msk});
			if (v < 0) break;
			expQ.push_back(v[5:0]);
			req[v] = 1'h0;
			while (expQ.size() != 0) @(posedge clk_sys);
			repeat (3) @(posedge clk_sys);
		end
		// held requests must stay unanswered here
		repeat (30) @(posedge clk_sys);
		modCond <= 64'h0;
		irqPinN <= 6'h3F;
		regWr(OFF_MASK, 32'h3);
		mk = 2'h3;
		repeat (4) @(posedge clk_sys);
	endtask

	// ********
	// result watcher
	// ********
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			badCount++;
			printVerdict();
		end
		if (!rst && excAck && expQ.size() != 0) begin
			chk("vector", {26'h0, expQ[0]}, {26'h0, vecNum});
		end
		if (!rst && memOut.wr) begin
			chk("stack addr", {8'h0, spIn - 24'h4}, {8'h0, memOut.addr});
			chk("saved pc", {8'h0, nextPc}, {8'h0, memOut.wdata[23:0]});
			chk("saved flags", {24'h0, mk[0], mk[1], 6'h0A}, {24'h0, memOut.wdata[31:24]});
		end
		if (!rst && jump) begin
			if (expQ.size() == 0) begin
				chk("unexpected jump", 32'h0, {8'h0, jumpPc});
			end else begin
				mv = expQ.pop_front();
				chk("handler", {16'h0010, adv ? {8'h0, mv, 2'h0} : {9'h0, mv, 1'h0}},
					{8'h0, jumpPc});
				chk("masks", {30'h0, 1'h1, m0}, {30'h0, maskI, maskSec});
				if (mv >= 6'd12 && mv < 6'd18) irqPinN[mv - 6'd12] <= 1'h1;
				else if (mv != 6'h07) modCond[mv] <= 1'h0;
			end
		end
	end

	// ********
	// main sequence
	// ********
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk("reset masks", 32'h1, {30'h0, maskSec, maskI});
		@(posedge clk_sys);
		regRd(OFF_SYSCTL, 32'h3, "sysctl");
		regRd(8'h40, 32'h0, "unmapped");
		round(1'h0, 1'h1, 2'h0, 16'h0);
		round(1'h0, 1'h1, 2'h0, 16'(rnd()));
		round(1'h0, 1'h0, 2'h1, 16'(rnd()));
		round(1'h1, 1'h0, 2'h2, 16'(rnd()));
		round(1'h1, 1'h1, 2'h1, 16'h2000);
		round(1'h1, 1'h1, 2'h1, 16'(rnd()));
		round(1'h1, 1'h0, 2'h3, 16'(rnd()));
		standbyPin <= 1'h1;
		nmiPinN <= 1'h0;
		repeat (20) @(posedge clk_sys);
		nmiPinN <= 1'h1;
		standbyPin <= 1'h0;
		repeat (6) @(posedge clk_sys);
		expQ.push_back(VEC_NMI);
		nmiPinN <= 1'h0;
		repeat (40) @(posedge clk_sys);
		chk("unserved", 32'h0, 32'(expQ.size()));
		printVerdict();
	end
endmodule
